// ### verilog/fsp_top.sv
// module: status output pin configuration logic with command and status port
//
// The address map and strobed register access are this design's own decisions.
`default_nettype none
// Contract
// - code 00 gives ready/busy level output
// - configuration starts at 00 after reset
// - code 01 pulses low on erase done
// - erase pulse on single or queued end
// - code 10 pulses low on program done
// - code 11 pulses on either completion
// - pulse stays low about 250 ns
// - invalid code sets both error flags
module fsp_top
  import fsp_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      resetn_i,
  input  wire logic [fsp_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [fsp_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output logic      [fsp_pkg::DATA_W-1:0] rdata_o,
  input  wire fsp_pkg::fsp_wsm_s         wsm_i,
  output logic                           status_output_pin_o
);
  import fsp_pkg::*;

  // ==========================================================================
  // helpers
  // ==========================================================================
  function automatic logic code_valid(input logic [7:0] d);
    return d[7:RSVD_LSB] == RSVD_ZERO;
  endfunction

  function automatic logic mode_fires(input fsp_mode_e m, input fsp_wsm_s w);
    logic f;
    f = 1'b0;
    case (m)
      FSP_ERASE_DONE_PULSE:   f = w.erase_done;
      FSP_PROGRAM_DONE_PULSE: f = w.program_done;
      FSP_ANY_DONE_PULSE:     f = w.erase_done | w.program_done;
      default:                f = 1'b0;
    endcase
    return f;
  endfunction

  // ==========================================================================
  // state
  // ==========================================================================
  fsp_state_s st;
  fsp_state_s next_st;

  logic cmd_wr;
  logic code_wr;
  logic fire;
  logic clr_wr;
  logic [1:0] code_field;
  assign cmd_wr  = wr_i && (addr_i == CMD_ADDR);
  assign code_wr = cmd_wr && st.armed;
  assign clr_wr  = wr_i && (addr_i == CLEAR_ADDR);
  assign fire    = mode_fires(st.cfg, wsm_i);
  assign code_field = wdata_i[CODE_LSB +: 2];

  always_comb
  begin
    next_st = st;
    // second byte always consumes the arm, valid or not
    if (code_wr)
    begin
      next_st.armed = 1'b0;
      if (code_valid(wdata_i))
      begin
        next_st.cfg = fsp_mode_e'(code_field);
      end
    end
    else if (cmd_wr && wdata_i == CONFIG_CMD)
    begin
      next_st.armed = 1'b1;
    end
    // error flags: an invalid code in the clearing cycle still sets them
    next_st.program_error = (code_wr && !code_valid(wdata_i))
                          | (st.program_error & ~clr_wr);
    next_st.erase_error   = (code_wr && !code_valid(wdata_i))
                          | (st.erase_error & ~clr_wr);
    // a valid code cancels a pending pulse, so the new mode starts clean
    if (code_wr && code_valid(wdata_i))
      next_st.cnt = '0;
    // retrigger restarts the full width so back-to-back completions merge
    else if (fire && !code_wr)
      next_st.cnt = CNT_W'(PULSE_CYC);
    else if (st.cnt != '0)
      next_st.cnt = st.cnt - CNT_W'(1);
    // the pin follows the mode in force before a code write takes effect
    if (st.cfg == FSP_READY_BUSY_LEVEL)
      next_st.pin = ~wsm_i.busy;
    else
      next_st.pin = (next_st.cnt == '0);
    // read data stand one cycle only, zero otherwise
    next_st.rdata = '0;
    if (rd_i && addr_i == STATUS_ADDR)
    begin
      next_st.rdata[MACHINE_READY_BIT] = ~wsm_i.busy;
      next_st.rdata[SUSPENDED_BIT]     = wsm_i.suspended;
      next_st.rdata[ERASE_ERROR_BIT]   = st.erase_error;
      next_st.rdata[PROGRAM_ERROR_BIT] = st.program_error;
      next_st.rdata[ARMED_BIT]         = st.armed;
      next_st.rdata[CFG_LSB +: 2]      = st.cfg;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st               <= '0;
      st.cfg           <= fsp_mode_e'(CFG_RESET);
      st.pin           <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rdata_o             = st.rdata;
  assign status_output_pin_o = st.pin;

  // ==========================================================================
  // checks
  // ==========================================================================
  // remembers a valid code so the reset default can be checked
  logic cfg_seen;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cfg_seen <= 1'b0;
    else if (code_wr && code_valid(wdata_i))
      cfg_seen <= 1'b1;
  end

  sequence valid_code_s;
    code_wr && code_valid(wdata_i);
  endsequence

  sequence pulse_start_s;
    fire && !code_wr;
  endsequence

  sequence low_hold_s;
    !status_output_pin_o [*8];
  endsequence

  level_mode_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    st.cfg == FSP_READY_BUSY_LEVEL |=> status_output_pin_o == !$past(wsm_i.busy))
    else $error("level mode pin does not follow ready state");

  reset_default_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    st.cfg != FSP_READY_BUSY_LEVEL |-> cfg_seen)
    else $error("pulse mode without a configuration write");

  erase_pulse_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (st.cfg == FSP_ERASE_DONE_PULSE && wsm_i.erase_done && !code_wr) |=> low_hold_s)
    else $error("no pulse after erase completion");

  erase_only_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (st.cfg == FSP_ERASE_DONE_PULSE && wsm_i.program_done && !wsm_i.erase_done
     && st.cnt == '0 && !code_wr) |=> status_output_pin_o)
    else $error("erase mode pulsed on program completion");

  program_pulse_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (st.cfg == FSP_PROGRAM_DONE_PULSE && wsm_i.program_done && !code_wr)
    |=> low_hold_s)
    else $error("no pulse after program completion");

  any_pulse_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (st.cfg == FSP_ANY_DONE_PULSE && (wsm_i.erase_done || wsm_i.program_done)
     && !code_wr) |=> !status_output_pin_o)
    else $error("no pulse in either-completion mode");

  pulse_width_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    pulse_start_s |=> (st.cnt == CNT_W'(PULSE_CYC)) && !status_output_pin_o)
    else $error("pulse counter not loaded with full width");

  pulse_end_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (st.cfg != FSP_READY_BUSY_LEVEL && st.cnt == '0) |-> status_output_pin_o)
    else $error("pin low after pulse width elapsed");

  invalid_code_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (code_wr && !code_valid(wdata_i)) |=> (st.program_error && st.erase_error
     && $stable(st.cfg)))
    else $error("invalid code did not set both error flags");

  cfg_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !(code_wr && code_valid(wdata_i)) |=> $stable(st.cfg))
    else $error("configuration changed without a valid code");

  cfg_load_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    valid_code_s |=> (st.cfg == $past(code_field)) && (st.cnt == '0))
    else $error("valid code not loaded or pulse not cancelled");

  pulse_count_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (st.cnt != '0 && !fire && !code_wr) |=> st.cnt == $past(st.cnt) - CNT_W'(1))
    else $error("pulse counter did not count down by one");

  error_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    clr_wr |=> !st.program_error && !st.erase_error)
    else $error("clear write left an error flag set");

  status_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (rd_i && addr_i == STATUS_ADDR) |=> rdata_o[ERASE_ERROR_BIT] == $past(st.erase_error)
     && rdata_o[PROGRAM_ERROR_BIT] == $past(st.program_error))
    else $error("status read does not show the error flags");

  code_disarm_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    code_wr |=> !st.armed)
    else $error("code byte did not consume the arm");

endmodule // fsp_top
`default_nettype wire

// ### verilog/fsp_pkg.sv
// package: constants and carrier types for the status pin configuration block
`default_nettype none
package fsp_pkg;

  // ==========================================================================
  // register port
  // ==========================================================================
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 8;
  localparam logic [3:0]  CMD_ADDR    = 4'h0;
  localparam logic [3:0]  STATUS_ADDR = 4'h4;
  localparam logic [3:0]  CLEAR_ADDR  = 4'h8;

  // ==========================================================================
  // command and configuration codes
  // ==========================================================================
  localparam logic [7:0]  CONFIG_CMD  = 8'hB8;
  localparam logic [5:0]  RSVD_ZERO   = 6'h00;
  localparam int          CODE_LSB    = 0;
  localparam int          RSVD_LSB    = 2;
  localparam logic [1:0]  CFG_RESET   = 2'h0;

  typedef enum logic [1:0] {
    FSP_READY_BUSY_LEVEL    = 2'b00,
    FSP_ERASE_DONE_PULSE    = 2'b01,
    FSP_PROGRAM_DONE_PULSE  = 2'b10,
    FSP_ANY_DONE_PULSE      = 2'b11
  } fsp_mode_e;

  // ==========================================================================
  // status byte layout
  // ==========================================================================
  localparam int          MACHINE_READY_BIT = 7;
  localparam int          SUSPENDED_BIT     = 6;
  localparam int          ERASE_ERROR_BIT   = 5;
  localparam int          PROGRAM_ERROR_BIT = 4;
  localparam int          ARMED_BIT         = 2;
  localparam int          CFG_LSB           = 0;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int          CLK_PERIOD_PS = 8000;
  localparam int          PULSE_NS      = 250;
  localparam int          PULSE_CYC     = (PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          CNT_W         = 6;

  // ==========================================================================
  // carriers
  // ==========================================================================
  typedef struct packed {
    logic busy;
    logic suspended;
    logic erase_done;
    logic program_done;
  } fsp_wsm_s;

  typedef struct packed {
    logic             armed;
    fsp_mode_e        cfg;
    logic             program_error;
    logic             erase_error;
    logic [CNT_W-1:0] cnt;
    logic             pin;
    logic [7:0]       rdata;
  } fsp_state_s;

endpackage
`default_nettype wire

// ### verif/fsp_host.sv
// host partner: command and status port cycles
`default_nettype none
module fsp_host
  import fsp_pkg::*;
(
  input  wire logic                        clk_i,
  output logic      [fsp_pkg::ADDR_W-1:0] addr_o,
  output logic      [fsp_pkg::DATA_W-1:0] wdata_o,
  output logic                             wr_o,
  output logic                             rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import fsp_pkg::*;

  initial
  begin
    {addr_o, wdata_o, wr_o, rd_o} = '0;
  end

  // ==========================================================
  // one strobe cycle; released address and data lines show the inverse value, strobes go low
  // ==========================================================
  task access(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    wr_o    <= w;
    rd_o    <= !w;
    addr_o  <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    rd_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask

  task configure(input logic [DATA_W-1:0] code);
    access(1'b1, CMD_ADDR, CONFIG_CMD);
    access(1'b1, CMD_ADDR, code);
  endtask
endmodule // fsp_host
`default_nettype wire

// ### verif/flash_status_pin_config_test.sv
// testbench: reference model of the status pin block compared every cycle out of reset after the first six
`default_nettype none
module flash_status_pin_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  import fsp_pkg::*;
  localparam int LOW_CYC = (250 * 1000 + 7999) / 8000;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o;
  logic wr_i, rd_i, status_output_pin_o, cw, ev, m_arm, m_pe, m_ee, m_pin;
  fsp_wsm_s wsm_i = '0;
  logic [1:0] m_cfg;
  logic [7:0] m_rd;
  int m_cnt, errors = 0, n_compared = 0, cyc = 0;

  always #4 clk_i = ~clk_i;

  fsp_host u_host (.clk_i(clk_i), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
  fsp_top u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .wsm_i(wsm_i),
    .status_output_pin_o(status_output_pin_o));

  // ==========================================================
  // reference model
  // ==========================================================
  always @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      {m_cfg, m_arm, m_pe, m_ee, m_rd, m_cnt} = '0;
      m_pin = 1'b1;
    end
    else
    begin
      cw = wr_i && addr_i == CMD_ADDR && m_arm;
      m_rd = (rd_i && addr_i == STATUS_ADDR) ?
        {!wsm_i.busy, wsm_i.suspended, m_ee, m_pe, 1'b0, m_arm, m_cfg} : 8'h00;
      if (wr_i && addr_i == CLEAR_ADDR) {m_pe, m_ee} = 2'b00;
      ev = !cw && ((m_cfg[0] && wsm_i.erase_done) || (m_cfg[1] && wsm_i.program_done));
      m_cnt = ev ? LOW_CYC : (m_cnt > 0 ? m_cnt - 1 : 0);
      if (cw && wdata_i[7:2] == 6'h00) m_cnt = 0;
      // the pin obeys the old mode in the cycle a code lands
      m_pin = (m_cfg == 2'b00) ? !wsm_i.busy : (m_cnt == 0);
      if (cw && wdata_i[7:2] == 6'h00) m_cfg = wdata_i[1:0];
      else if (cw) {m_pe, m_ee} = 2'b11;
      if (wr_i && addr_i == CMD_ADDR) m_arm = !m_arm && wdata_i == CONFIG_CMD;
    end

  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  always @(negedge clk_i)
    if (resetn_i && cyc > 6)
    begin
      check(8'(status_output_pin_o), 8'(m_pin));
      check(rdata_o, m_rd);
    end

  task give_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      give_verdict();
    end
  end

  // random events then a quiet tail so no pulse is pending at reconfig
  task run(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      wsm_i <= {1'($urandom_range(1)), 1'($urandom_range(1)),
                1'($urandom_range(30) == 0), 1'($urandom_range(30) == 0)};
    end
    @(posedge clk_i);
    wsm_i <= '0;
    repeat (40) @(posedge clk_i);
    u_host.access(1'b0, STATUS_ADDR, 8'h00);
  endtask

  initial
  begin
    void'($urandom(32'hB8E6));
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    u_host.access(1'b0, STATUS_ADDR, 8'h00);
    run(100);
    $display("startup test done");
    for (int m = 0; m < 4; m++)
    begin
      u_host.configure(8'(m % 4));
      run(300);
      $display("mode %0d test done", m % 4);
    end
    u_host.configure(8'h01);
    u_host.configure(8'(8'h04 << $urandom_range(5)) | 8'h02);
    u_host.access(1'b0, STATUS_ADDR, 8'h00);
    u_host.access(1'b1, CMD_ADDR, CONFIG_CMD);
    u_host.access(1'b1, CLEAR_ADDR, 8'h00);
    u_host.access(1'b1, CMD_ADDR, CONFIG_CMD);
    u_host.access(1'b0, 4'hC, 8'h00);
    run(200);
    $display("invalid code test done");
    // a valid code in mid-pulse must cancel the pulse at once
    u_host.configure(8'h03);
    @(posedge clk_i);
    wsm_i <= 4'h2;
    @(posedge clk_i);
    wsm_i <= '0;
    u_host.configure(8'h01);
    run(50);
    $display("cancel test done");
    u_host.configure(8'h02);
    run(50);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    run(100);
    $display("reset test done");
    give_verdict();
  end
endmodule // flash_status_pin_config_test
`default_nettype wire
